// file: verilog/trf_defs.vh
// constants of the tape read formatter control block
// How it works
// - phase-encoded: dropout on two or more tracks sets hard error
// - group-coded: three or more dropped tracks, CRC or aux CRC fail set hard error
// - NRZI: CRC or LRC check mismatch sets hard error
// - corrected error: one track in PE, one or two tracks in group-coded
// - filemark flag rises on any filemark, in every density except none
// - check character gate pulled low while NRZI check characters detected
// - data available rises once a read command is held and envelope low
// - read gate pulled low once a read command is held and envelope low
// - align low at preamble start, high after two thirds, low at marker
// - marker found only when start marker seen on every track
// - sync found only when sync subgroup seen on every track
// - hard, corrected, filemark, check character latched into status register
// - density command selects group-coded, dual PE, PE or NRZI operation
// - corrected error report mode: all, two-track only, or none
// - error report command can force hard error true
// - stop command aborts the executing command at once
// - read mode: id burst, forward, reverse, space forward, space reverse
// - controller picks threshold per activity; device applies the chosen one
// - extended status command returns extended status for the host
// - eight-bit threshold code drives reference shared by nine channels
// - one six-bit gain converter time-shared over nine channel slots
// - serial transfer is address byte then command byte into that register
`ifndef TRF_DEFS_VH
`define TRF_DEFS_VH
// ********************************
// apb map
// ********************************
`define TRF_OFS_STATUS 8'h00
`define TRF_OFS_CONFIG 8'h04
`define TRF_OFS_CMD 8'h08
`define TRF_OFS_LEVELS 8'h0C
`define TRF_OFS_EXT 8'h10
// ********************************
// serial command addresses
// ********************************
`define TRF_CA_DENSITY 8'h01
`define TRF_CA_WCUR 8'h02
`define TRF_CA_THRESH 8'h03
`define TRF_CA_RDMODE 8'h04
`define TRF_CA_ERRREP 8'h05
`define TRF_CA_EXTSTAT 8'h06
`define TRF_CA_STOP 8'h07
`define TRF_CA_CAL 8'h08
`define TRF_CA_GAIN0 8'h10
// ********************************
// codes and fields
// ********************************
`define TRF_DEN_NONE 3'h0
`define TRF_DEN_GCR 3'h1
`define TRF_DEN_DPE 3'h2
`define TRF_DEN_PE 3'h3
`define TRF_DEN_NRZI 3'h4
`define TRF_RM_IDLE 3'h0
`define TRF_RM_ID 3'h1
`define TRF_RM_FWD 3'h2
`define TRF_RM_REV 3'h3
`define TRF_RM_SPF 3'h4
`define TRF_RM_SPR 3'h5
`define TRF_CR_ALL 2'h0
`define TRF_CR_TWO 2'h1
`define TRF_CR_NONE 2'h2
`define TRF_ERR_FORCE_BIT 2
`define TRF_ST_HARD 0
`define TRF_ST_CORR 1
`define TRF_ST_FMK 2
`define TRF_ST_CCG 3
// ********************************
// timing
// ********************************
`define TRF_CLK_MHZ 10
`define TRF_SLOT_NS 1000
`define TRF_SLOT_CYC ((`TRF_SLOT_NS * `TRF_CLK_MHZ) / 1000)
`define TRF_PRE_LEN 12'd48
`endif

// file: verilog/trf_sync2.v
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module trf_sync2
#(
    parameter RESET_VAL = 1'b0
)
(
    input wire pclk,
    input wire presetn,
    input wire d,
    output wire q
);
    reg meta_reg;
    reg sync_reg;
    // meta_reg feeds sync_reg only
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
        end
        else
        begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end
    assign q = sync_reg;
endmodule // trf_sync2

// file: verilog/trf_ctrl.v
// read formatter control: serial commands, error flags, framing, dacs
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "trf_defs.vh"
module trf_ctrl
#(
    parameter NTRK = 9,
    parameter PRE_LEN = `TRF_PRE_LEN,
    parameter EXT_INFO = 8'h5A
)
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire ser_clk,
    input wire ser_data,
    input wire ser_frame_n,
    input wire envelope_active_n,
    input wire [8:0] trk_dropout,
    input wire crc_fail,
    input wire auxiliary_crc_fail,
    input wire lrc_fail,
    input wire filemark_det,
    input wire check_char_det,
    input wire preamble_active,
    input wire [8:0] data_start_marker,
    input wire [8:0] sync_subgroup,
    output reg hard_error_flag,
    output reg corrected_error_flag,
    output reg filemark_flag,
    output reg check_char_gate_n,
    output reg data_avail_flag,
    output reg read_gate_n,
    output reg align_window,
    output reg marker_found,
    output reg sync_found,
    output wire [7:0] read_threshold_level,
    output reg [5:0] gain_level_muxed,
    output reg [8:0] gain_slot_sel,
    output wire [5:0] write_current_level,
    output reg [7:0] ext_status_data,
    output reg ext_status_valid
);
    // ********************************
    // pin synchronisers
    // ********************************
    wire sclk_s;
    wire sdat_s;
    wire sfrm_n_s;
    wire env_n_s;
    trf_sync2 #(.RESET_VAL(1'b0)) u_sclk (.pclk(pclk), .presetn(presetn), .d(ser_clk), .q(sclk_s));
    trf_sync2 #(.RESET_VAL(1'b0)) u_sdat (.pclk(pclk), .presetn(presetn), .d(ser_data), .q(sdat_s));
    trf_sync2 #(.RESET_VAL(1'b1)) u_sfrm (.pclk(pclk), .presetn(presetn), .d(ser_frame_n), .q(sfrm_n_s));
    trf_sync2 #(.RESET_VAL(1'b1)) u_env (.pclk(pclk), .presetn(presetn), .d(envelope_active_n), .q(env_n_s));

    function [3:0] ones9;
        input [8:0] v;
        integer i;
        begin
            ones9 = 4'h0;
            for (i = 0; i < 9; i = i + 1)
                ones9 = ones9 + {3'h0, v[i]};
        end
    endfunction

    // ********************************
    // serial receiver
    // ********************************
    reg sclk_d_reg;
    reg [15:0] sh_reg;
    reg [4:0] bits_reg;
    reg frm_d_reg;
    wire sclk_rise = sclk_s & ~sclk_d_reg;
    wire frm_end = sfrm_n_s & ~frm_d_reg;
    wire ser_cmd = frm_end && (bits_reg == 5'd16);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_d_reg <= 1'b0;
            frm_d_reg <= 1'b1;
            sh_reg <= 16'h0000;
            bits_reg <= 5'h00;
        end
        else
        begin
            sclk_d_reg <= sclk_s;
            frm_d_reg <= sfrm_n_s;
            if (sfrm_n_s)
                bits_reg <= 5'h00;
            else if (sclk_rise && bits_reg != 5'd16)
            begin
                // msb first: address byte, then command byte
                sh_reg <= {sh_reg[14:0], sdat_s};
                bits_reg <= bits_reg + 5'h01;
            end
        end
    end

    // ********************************
    // apb slave
    // ********************************
    wire setup = psel & ~penable;
    wire acc = psel & penable;
    wire mapped = (paddr == `TRF_OFS_STATUS) || (paddr == `TRF_OFS_CONFIG) ||
        (paddr == `TRF_OFS_CMD) || (paddr == `TRF_OFS_LEVELS) || (paddr == `TRF_OFS_EXT);
    wire apb_wr = acc & pwrite;
    wire apb_cmd = apb_wr && (paddr == `TRF_OFS_CMD);
    wire st_clr = apb_wr && (paddr == `TRF_OFS_STATUS);
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    // apb command wins a same-cycle clash; serial one is dropped
    wire cmd_go = apb_cmd | ser_cmd;
    wire [7:0] cmd_adr = apb_cmd ? pwdata[15:8] : sh_reg[15:8];
    wire [7:0] cmd_val = apb_cmd ? pwdata[7:0] : sh_reg[7:0];

    // ********************************
    // command registers
    // ********************************
    reg [2:0] density_reg;
    reg [2:0] rdmode_reg;
    reg [1:0] crmode_reg;
    reg force_her_reg;
    reg [7:0] thresh_reg;
    reg [5:0] wcur_reg;
    reg cal_reg;
    reg [5:0] gain_mem [0:NTRK-1];
    integer g;
    wire gain_cmd = cmd_go && cmd_adr >= `TRF_CA_GAIN0 && cmd_adr < `TRF_CA_GAIN0 + NTRK;
    wire [3:0] gain_idx = cmd_adr[3:0];
    wire stop_cmd = cmd_go && cmd_adr == `TRF_CA_STOP;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            density_reg <= `TRF_DEN_NONE;
            rdmode_reg <= `TRF_RM_IDLE;
            crmode_reg <= `TRF_CR_ALL;
            force_her_reg <= 1'b0;
            thresh_reg <= 8'h00;
            wcur_reg <= 6'h00;
            cal_reg <= 1'b0;
            ext_status_data <= 8'h00;
            ext_status_valid <= 1'b0;
            for (g = 0; g < NTRK; g = g + 1)
                gain_mem[g] <= 6'h00;
        end
        else
        begin
            ext_status_valid <= 1'b0;
            if (stop_cmd)
            begin
                // abort: read/space and calibration end, forced error dropped
                rdmode_reg <= `TRF_RM_IDLE;
                cal_reg <= 1'b0;
                force_her_reg <= 1'b0;
            end
            else if (cmd_go)
            begin
                case (cmd_adr)
                    `TRF_CA_DENSITY:
                        if (cmd_val[2:0] <= `TRF_DEN_NRZI)
                            density_reg <= cmd_val[2:0];
                    `TRF_CA_WCUR:
                        wcur_reg <= cmd_val[5:0];
                    `TRF_CA_THRESH:
                        thresh_reg <= cmd_val;
                    `TRF_CA_RDMODE:
                        if (cmd_val[2:0] <= `TRF_RM_SPR)
                            rdmode_reg <= cmd_val[2:0];
                    `TRF_CA_ERRREP:
                    begin
                        if (cmd_val[1:0] <= `TRF_CR_NONE)
                            crmode_reg <= cmd_val[1:0];
                        force_her_reg <= cmd_val[`TRF_ERR_FORCE_BIT];
                    end
                    `TRF_CA_EXTSTAT:
                    begin
                        ext_status_data <= EXT_INFO ^ {density_reg, rdmode_reg, crmode_reg};
                        ext_status_valid <= 1'b1;
                    end
                    `TRF_CA_CAL:
                        // trusted to arrive only on a read at beginning of tape
                        cal_reg <= cmd_val[0];
                    default:
                        if (gain_cmd)
                            gain_mem[gain_idx] <= cmd_val[5:0];
                endcase
            end
        end
    end
    assign read_threshold_level = thresh_reg;
    assign write_current_level = wcur_reg;

    // ********************************
    // error classification
    // ********************************
    wire is_gcr = density_reg == `TRF_DEN_GCR;
    wire is_pe = density_reg == `TRF_DEN_PE || density_reg == `TRF_DEN_DPE;
    wire is_nrzi = density_reg == `TRF_DEN_NRZI;
    wire [3:0] ndrop = ones9(trk_dropout);
    wire her_pe = is_pe && ndrop >= 4'd2;
    wire her_gcr = is_gcr && (ndrop >= 4'd3 || crc_fail || auxiliary_crc_fail);
    wire her_nrzi = is_nrzi && (crc_fail || lrc_fail);
    wire her_now = her_pe | her_gcr | her_nrzi | force_her_reg;
    wire cer_one = (is_pe || is_gcr) && ndrop == 4'd1;
    wire cer_two = is_gcr && ndrop == 4'd2;
    reg cer_now;
    always @*
    begin
        case (crmode_reg)
            `TRF_CR_ALL: cer_now = cer_one | cer_two;
            `TRF_CR_TWO: cer_now = cer_two;
            default: cer_now = 1'b0;
        endcase
    end
    wire fmk_now = filemark_det && density_reg != `TRF_DEN_NONE;
    wire ccg_now = is_nrzi && check_char_det;
    wire rd_active = rdmode_reg != `TRF_RM_IDLE;

    // ********************************
    // flag outputs and status register
    // ********************************
    reg [3:0] status_reg;
    wire [3:0] st_set = {ccg_now, fmk_now, cer_now, her_now};
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hard_error_flag <= 1'b0;
            corrected_error_flag <= 1'b0;
            filemark_flag <= 1'b0;
            check_char_gate_n <= 1'b1;
            data_avail_flag <= 1'b0;
            read_gate_n <= 1'b1;
            status_reg <= 4'h0;
        end
        else
        begin
            hard_error_flag <= her_now;
            corrected_error_flag <= cer_now;
            filemark_flag <= fmk_now;
            check_char_gate_n <= ~ccg_now;
            data_avail_flag <= rd_active & ~env_n_s;
            read_gate_n <= ~(rd_active & ~env_n_s);
            // write-one clear, but a new event in the same cycle survives
            status_reg <= (status_reg & ~(st_clr ? pwdata[3:0] : 4'h0)) | st_set;
        end
    end

    // ********************************
    // group-coded framing
    // ********************************
    localparam integer ALIGN_AT = (PRE_LEN * 2) / 3;
    localparam [2:0] FR_IDLE = 3'b001;
    localparam [2:0] FR_PRE = 3'b010;
    localparam [2:0] FR_DATA = 3'b100;
    reg [2:0] fr_reg;
    reg [11:0] pre_cnt_reg;
    wire all_mark = &data_start_marker;
    wire all_sync = &sync_subgroup;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fr_reg <= FR_IDLE;
            pre_cnt_reg <= 12'h000;
            align_window <= 1'b0;
            marker_found <= 1'b0;
            sync_found <= 1'b0;
        end
        else
        begin
            marker_found <= is_gcr & all_mark;
            sync_found <= is_gcr & all_sync;
            if (!is_gcr || stop_cmd)
            begin
                fr_reg <= FR_IDLE;
                align_window <= 1'b0;
            end
            else
            begin
                case (fr_reg)
                    FR_IDLE:
                        if (preamble_active)
                        begin
                            fr_reg <= FR_PRE;
                            pre_cnt_reg <= 12'h001;
                            align_window <= 1'b0;
                        end
                    FR_PRE:
                        if (all_mark)
                        begin
                            fr_reg <= FR_DATA;
                            align_window <= 1'b0;
                        end
                        else
                        begin
                            if (pre_cnt_reg != 12'hFFF)
                                pre_cnt_reg <= pre_cnt_reg + 12'h001;
                            if (pre_cnt_reg >= ALIGN_AT[11:0])
                                align_window <= 1'b1;
                        end
                    FR_DATA:
                    begin
                        // stays low through the data portion
                        align_window <= 1'b0;
                        if (!preamble_active && !all_mark && rdmode_reg == `TRF_RM_IDLE)
                            fr_reg <= FR_IDLE;
                    end
                    default:
                        fr_reg <= FR_IDLE;
                endcase
            end
        end
    end

    // ********************************
    // multiplexed gain converter
    // ********************************
    localparam integer SLOT_CYC = `TRF_SLOT_CYC;
    reg [7:0] div_reg;
    reg [3:0] slot_reg;
    wire slot_tick = div_reg == SLOT_CYC[7:0] - 8'h01;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_reg <= 8'h00;
            slot_reg <= 4'h0;
            gain_level_muxed <= 6'h00;
            gain_slot_sel <= 9'h000;
        end
        else
        begin
            div_reg <= slot_tick ? 8'h00 : div_reg + 8'h01;
            if (slot_tick)
            begin
                // one value per slot; the driver latches on its select
                gain_level_muxed <= gain_mem[slot_reg];
                gain_slot_sel <= 9'h001 << slot_reg;
                slot_reg <= (slot_reg == NTRK - 1) ? 4'h0 : slot_reg + 4'h1;
            end
        end
    end

    // ********************************
    // read data
    // ********************************
    reg [31:0] rdata_reg;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_reg <= 32'h00000000;
        else if (setup)
        begin
            case (paddr)
                `TRF_OFS_STATUS:
                    rdata_reg <= {22'h0, cal_reg, sync_found, marker_found, align_window,
                        data_avail_flag, force_her_reg, status_reg};
                `TRF_OFS_CONFIG:
                    rdata_reg <= {24'h0, crmode_reg, rdmode_reg, density_reg};
                `TRF_OFS_LEVELS:
                    rdata_reg <= {18'h0, wcur_reg, thresh_reg};
                `TRF_OFS_EXT:
                    rdata_reg <= {24'h0, ext_status_data};
                default:
                    rdata_reg <= 32'h00000000;
            endcase
        end
    end
    assign prdata = rdata_reg;
endmodule // trf_ctrl

// file: sim/trf_ctrl_sva.sv
// assertion checker for the tape read formatter control ports
`timescale 1ns/1ps
module trf_ctrl_sva
#(
    parameter PRE_LEN = 48
)
(
    input wire pclk,
    input wire presetn,
    input wire envelope_active_n,
    input wire [8:0] trk_dropout,
    input wire filemark_det,
    input wire check_char_det,
    input wire preamble_active,
    input wire [8:0] data_start_marker,
    input wire [8:0] sync_subgroup,
    input wire corrected_error_flag,
    input wire filemark_flag,
    input wire check_char_gate_n,
    input wire data_avail_flag,
    input wire align_window,
    input wire marker_found,
    input wire sync_found,
    input wire [8:0] gain_slot_sel
);
    // ****************
    // helper state
    // ****************
    localparam int ALIGN_AT = PRE_LEN * 2 / 3;
    logic [8:0] prev_slot;
    logic [11:0] pre_cnt;
    // no reset: only looked at while the checks are enabled
    always @(posedge pclk)
    begin
        prev_slot <= gain_slot_sel;
        pre_cnt <= preamble_active ? pre_cnt + 12'h001 : 12'h000;
    end
    // ****************
    // properties
    // ****************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_all_mark; data_start_marker == 9'h1FF; endsequence
    property p_mark_low; s_all_mark |=> (!align_window) [*3]; endproperty
    a_mark_low: assert property (p_mark_low) else $error("align high after marker");
    property p_align; align_window && preamble_active |-> pre_cnt > ALIGN_AT; endproperty
    a_align: assert property (p_align) else $error("align rose too early");
    property p_corr; corrected_error_flag |-> $countones($past(trk_dropout)) inside {1, 2}; endproperty
    a_corr: assert property (p_corr) else $error("corrected flag without cause");
    property p_fmk; filemark_flag |-> $past(filemark_det); endproperty
    a_fmk: assert property (p_fmk) else $error("filemark flag without cause");
    property p_ccg; !check_char_gate_n |-> $past(check_char_det); endproperty
    a_ccg: assert property (p_ccg) else $error("check gate low without cause");
    property p_data_avail_flag; data_avail_flag |-> !$past(envelope_active_n, 3); endproperty
    a_data_avail_flag: assert property (p_data_avail_flag) else $error("data available without envelope");
    property p_mark; marker_found |-> $past(data_start_marker) == 9'h1FF; endproperty
    a_mark: assert property (p_mark) else $error("marker found on partial tracks");
    property p_sync; sync_found |-> $past(sync_subgroup) == 9'h1FF; endproperty
    a_sync: assert property (p_sync) else $error("sync found on partial tracks");
    property p_slot;
        $changed(gain_slot_sel) && prev_slot != 9'h000 |-> gain_slot_sel == {prev_slot[7:0], prev_slot[8]};
    endproperty
    a_slot: assert property (p_slot) else $error("gain slot out of order");
    property p_slot_hold; $changed(gain_slot_sel) |=> $stable(gain_slot_sel) [*8]; endproperty
    a_slot_hold: assert property (p_slot_hold) else $error("gain slot too short");
endmodule // trf_ctrl_sva

bind trf_ctrl trf_ctrl_sva #(.PRE_LEN(PRE_LEN)) trf_ctrl_sva_i (.*);

// file: sim/trf_ser_master.sv
// serial command master standing in for the drive controller
`timescale 1ns/1ps
module trf_ser_master
(
    input wire pclk,
    output logic ser_clk,
    output logic ser_data,
    output logic ser_frame_n
);
    // clock parks low between frames; data shows the inverse of its last bit
    initial
    begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_frame_n = 1'b1;
    end
    // half is the serial half period in pclk cycles, 3 at the fastest
    // calibration never sent: no read from tape start here
    task automatic send(input logic [7:0] addr, input logic [7:0] cmd, input int half);
        logic [15:0] w;
        w = {addr, cmd};
        @(posedge pclk);
        ser_frame_n <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            ser_data <= w[i];
            repeat (half) @(posedge pclk);
            ser_clk <= 1'b1;
            repeat (half) @(posedge pclk);
            ser_clk <= 1'b0;
        end
        repeat (half) @(posedge pclk);
        ser_frame_n <= 1'b1;
        ser_data <= ~w[0];
        repeat (6) @(posedge pclk);
    endtask
endmodule // trf_ser_master

// file: sim/trf_ctrl_bench.sv
// self-checking bench for the tape read formatter control block
`timescale 1ns/1ps
`include "trf_defs.vh"
module trf_ctrl_bench;
    logic pclk, presetn, psel, penable, pwrite, envelope_active_n, preamble_active;
    logic crc_fail, auxiliary_crc_fail, lrc_fail, filemark_det, check_char_det;
    logic [7:0] paddr, val;
    logic [31:0] pwdata;
    logic [8:0] trk_dropout, data_start_marker, sync_subgroup;
    wire [31:0] prdata;
    wire pready, pslverr, ser_clk, ser_data, ser_frame_n, hard_error_flag, filemark_flag;
    wire corrected_error_flag, check_char_gate_n, data_avail_flag, read_gate_n;
    wire align_window, marker_found, sync_found, ext_status_valid;
    wire [7:0] read_threshold_level, ext_status_data;
    wire [5:0] gain_level_muxed, write_current_level;
    wire [8:0] gain_slot_sel;
    int errors = 0;
    int cmp_count = 0;
    int seed = 32'hb901;
    logic [31:0] exp_q[$];
    logic [31:0] mask_q[$];
    localparam logic [7:0] EXT_INFO = 8'h3C; // arbitrary value
    trf_ctrl #(.PRE_LEN(12), .EXT_INFO(EXT_INFO)) trf_ctrl_i (.*);
    trf_ser_master trf_ser_master_i (.*);
    // ****************
    // tasks
    // ****************
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        mask_q.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic cmd(input logic [7:0] a, input logic [7:0] b);
        apb(1'b1, 8'h08, {16'h0, a, b});
    endtask
    // one-cycle event, then the sticky status is read and cleared
    task automatic flags(input logic [8:0] d, input logic [4:0] m, input logic [3:0] e);
        @(posedge pclk);
        trk_dropout <= d;
        {crc_fail, auxiliary_crc_fail, lrc_fail, filemark_det, check_char_det} <= m;
        @(posedge pclk);
        trk_dropout <= 9'h000;
        {crc_fail, auxiliary_crc_fail, lrc_fail, filemark_det, check_char_det} <= 5'h00;
        tick(3);
        rd(8'h00, {28'h0, e}, 32'hF);
        apb(1'b1, 8'h00, 32'hF);
    endtask
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ****************
    // checking
    // ****************
    always @(posedge pclk)
    begin
        if (psel && penable && pready && !pwrite)
            compare({pslverr, prdata[30:0]} & mask_q.pop_front(), exp_q.pop_front());
    end
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial
    begin
        tick(30000);
        errors++;
        $display("watchdog expired");
        report_and_stop;
    end
    // ****************
    // scenarios
    // ****************
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {crc_fail, auxiliary_crc_fail, lrc_fail, filemark_det, check_char_det} = 5'h00;
        {preamble_active, trk_dropout, data_start_marker, sync_subgroup} = '0;
        envelope_active_n = 1'b1;
        presetn = 1'b0;
        tick(4);
        presetn <= 1'b1;
        rd(8'h00, 32'h0, 32'h3F);
        rd(8'h04, 32'h0, 32'hFF);
        compare({31'h0, read_gate_n}, 32'h1);
        rd(8'h20, 32'h80000000, 32'hFFFFFFFF);
        for (int k = 4; k >= 1; k--)
        begin
            trf_ser_master_i.send(`TRF_CA_DENSITY, 8'(k), 3 + k % 3);
            rd(8'h04, 32'(k), 32'h7);
        end
        $display("reset and density tests done");
        flags(9'h003, 5'h00, 4'h2);
        flags(9'h007, 5'h00, 4'h1);
        flags(9'h000, 5'h10, 4'h1);
        flags(9'h000, 5'h08, 4'h1);
        for (int k = 0; k < 3; k++)
        begin
            cmd(`TRF_CA_ERRREP, 8'(k));
            rd(8'h04, 32'(k) << 6, 32'hC0);
            flags(9'h100, 5'h00, {2'h0, k == 0, 1'b0});
            flags(9'h180, 5'h00, {2'h0, k < 2, 1'b0});
        end
        @(posedge pclk);
        preamble_active <= 1'b1;
        tick(10);
        compare({31'h0, align_window}, 32'h1);
        data_start_marker <= 9'h0FF;
        sync_subgroup <= 9'h1FF;
        tick(1);
        {preamble_active, sync_subgroup, data_start_marker} <= {10'h0, 9'h1FF};
        tick(1);
        data_start_marker <= 9'h000;
        tick(2);
        compare({31'h0, align_window}, 32'h0);
        cmd(`TRF_CA_ERRREP, 8'h04);
        rd(8'h00, 32'h1, 32'h1);
        cmd(`TRF_CA_STOP, 8'h00);
        apb(1'b1, 8'h00, 32'hF);
        rd(8'h00, 32'h0, 32'h1);
        for (int k = 1; k <= 5; k++)
        begin
            cmd(`TRF_CA_RDMODE, 8'(k));
            rd(8'h04, 32'(k) << 3, 32'h38);
        end
        envelope_active_n <= 1'b0;
        tick(5);
        compare({30'h0, data_avail_flag, read_gate_n}, 32'h2);
        cmd(`TRF_CA_STOP, 8'h00);
        tick(2);
        compare({30'h0, data_avail_flag, read_gate_n}, 32'h1);
        envelope_active_n <= 1'b1;
        $display("group-coded and mode tests done");
        trf_ser_master_i.send(`TRF_CA_DENSITY, {5'h0, `TRF_DEN_NRZI}, 4);
        flags(9'h000, 5'h04, 4'h1);
        flags(9'h000, 5'h10, 4'h1);
        flags(9'h000, 5'h01, 4'h8);
        flags(9'h000, 5'h02, 4'h4);
        trf_ser_master_i.send(`TRF_CA_EXTSTAT, 8'h00, 3);
        val = EXT_INFO ^ {`TRF_DEN_NRZI, `TRF_RM_IDLE, `TRF_CR_ALL};
        rd(8'h10, {24'h0, val}, 32'hFF);
        trf_ser_master_i.send(`TRF_CA_DENSITY, {5'h0, `TRF_DEN_PE}, 3);
        flags(9'h010, 5'h00, 4'h2);
        flags(9'h011, 5'h00, 4'h1);
        flags(9'h1C0, 5'h00, 4'h1);
        $display("nrzi and phase-encoded tests done");
        val = 8'($random(seed));
        trf_ser_master_i.send(`TRF_CA_THRESH, val, 6);
        rd(8'h0C, {24'h0, val}, 32'hFF);
        compare({24'h0, read_threshold_level}, {24'h0, val});
        cmd(`TRF_CA_WCUR, val & 8'h3F);
        rd(8'h0C, {18'h0, val[5:0], 8'h0}, 32'h3F00);
        compare({26'h0, write_current_level}, {26'h0, val[5:0]});
        for (int k = 0; k < 9; k++)
        begin
            val = 8'($random(seed)) & 8'h3F;
            trf_ser_master_i.send(`TRF_CA_GAIN0 + 8'(k), val, 3);
            // let a slot latched before the command pass
            tick(11);
            for (int t = 0; t < 100 && gain_slot_sel[k] !== 1'b1; t++)
                tick(1);
            compare({26'h0, gain_level_muxed}, {24'h0, val});
        end
        $display("level and gain tests done");
        report_and_stop;
    end
endmodule // trf_ctrl_bench
